/* File: hdl/svd_ctrl_defs.svh */
// Offsets, field positions, reset values and timing counts of the supply voltage detector
`ifndef SVD_CTRL_DEFS_SVH
`define SVD_CTRL_DEFS_SVH

`define ADDR_W                16
`define DATA_W                4
`define OFF_THRESHOLD_SELECT  16'hFF04
`define OFF_DETECTOR_CONTROL  16'hFF05
`define OFF_IRQ_STATUS        16'hFF06
`define OFF_IRQ_MASK          16'hFF08
`define BIT_DETECTOR_ENABLE   0
`define BIT_LOW_SUPPLY_RESULT 1
`define BIT_IRQ_DONE          0
`define BIT_IRQ_LOW           1
`define BIT_IRQ_EARLY         2
`define RST_THRESHOLD         4'h0
`define RST_CONTROL           4'h0
`define SETTLE_TIME_US        100
`define CLK_MHZ               100
`define SETTLE_CYCLES         (`SETTLE_TIME_US * `CLK_MHZ)

`endif

/* File: hdl/svd_ctrl_pkg.sv */
// Types shared by the supply voltage detector control block
package svd_ctrl_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [15:0] addr;
        logic [3:0] wdata;
    } bus_req_s;

    typedef enum logic [1:0] {
        DET_OFF,
        DET_SETTLING,
        DET_SETTLED
    } det_state_e;
endpackage : svd_ctrl_pkg

/* File: hdl/sync2.sv */
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module sync2 (
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    logic meta_next;
    logic q_next;

    always_comb begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            q_o      <= q_next;
        end
    end
endmodule : sync2

/* File: hdl/supply_voltage_detect_ctrl.sv */
// Control and result registers of the on-chip supply voltage detector
// How it works
// - Four-bit threshold code picks 1.30 V plus 0.10 V per step, read/write.
// - Reset clears the threshold code to zero, the lowest level.
// - Enable bit powers the comparator, reads back, resets to zero.
// - On enable falling one to zero, comparator outcome is latched, then off.
// - Result reads zero when supply at or above threshold, one when below.
// - Result holds the last captured value; writes to it do nothing.
// - Reset clears the result latch to zero, meaning normal supply.
// - Upper two bits of the control/result register always read zero.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "svd_ctrl_defs.svh"
module supply_voltage_detect_ctrl
    import svd_ctrl_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic [`ADDR_W-1:0]  addr_i,
    input  wire logic [`DATA_W-1:0]  wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [`DATA_W-1:0]  rdata_o,
    input  wire logic                cmp_below_i,
    output logic                     detector_enable_o,
    output logic      [3:0]          threshold_select_o,
    output logic                     irq_o
);
    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 1000000)
            $error("SETTLE_CYCLES out of range");
    end

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

    // ==========================================================
    // Bus request and comparator input
    // ==========================================================
    bus_req_s req;
    logic     cmp_below_sync;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    // Analogue comparator output is asynchronous to the system clock
    sync2 u_cmp_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (cmp_below_i),
        .q_o       (cmp_below_sync)
    );

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // ==========================================================
    // Registers
    // ==========================================================
    logic [3:0]         thr_reg, thr_next;
    logic               en_reg, en_next;
    logic               result_reg, result_next;
    logic [2:0]         status_reg, status_next;
    logic [2:0]         mask_reg, mask_next;
    logic [3:0]         rdata_next;
    logic               irq_next;
    det_state_e         state_reg, state_next;
    logic [CNT_W-1:0]   cnt_reg, cnt_next;
    logic               disable_evt;

    always_comb begin
        thr_next    = thr_reg;
        en_next     = en_reg;
        result_next = result_reg;
        mask_next   = mask_reg;
        status_next = status_reg;
        state_next  = state_reg;
        cnt_next    = cnt_reg;

        if (req.wr && hit(req.addr, `OFF_THRESHOLD_SELECT))
            thr_next = req.wdata;
        if (req.wr && hit(req.addr, `OFF_DETECTOR_CONTROL))
            en_next = req.wdata[`BIT_DETECTOR_ENABLE];
        if (req.wr && hit(req.addr, `OFF_IRQ_MASK))
            mask_next = req.wdata[2:0];

        // Falling enable: latch the comparator outcome; result bit is write-ignored
        disable_evt = en_reg && !en_next;
        if (disable_evt)
            result_next = cmp_below_sync;

        // Settling tracker: flags a disable that came before the stable time
        case (state_reg)
            DET_OFF: begin
                cnt_next = '0;
                if (en_reg)
                    state_next = DET_SETTLING;
            end
            DET_SETTLING: begin
                if (cnt_reg == CNT_W'(SETTLE_CYCLES - 1))
                    state_next = DET_SETTLED;
                else
                    cnt_next = cnt_reg + CNT_W'(1);
            end
            DET_SETTLED: begin
            end
            default: state_next = DET_OFF;
        endcase
        if (!en_reg)
            state_next = DET_OFF;

        // Write-one-to-clear, then events set; set wins over clear
        if (req.wr && hit(req.addr, `OFF_IRQ_STATUS))
            status_next = status_reg & ~req.wdata[2:0];
        if (disable_evt) begin
            status_next[`BIT_IRQ_DONE] = 1'b1;
            if (cmp_below_sync)
                status_next[`BIT_IRQ_LOW] = 1'b1;
            if (state_reg != DET_SETTLED)
                status_next[`BIT_IRQ_EARLY] = 1'b1;
        end

        irq_next = |(status_next & mask_next);

        rdata_next = 4'h0;
        if (req.rd) begin
            if (hit(req.addr, `OFF_THRESHOLD_SELECT))
                rdata_next = thr_reg;
            else if (hit(req.addr, `OFF_DETECTOR_CONTROL))
                rdata_next = {2'b00, result_reg, en_reg};
            else if (hit(req.addr, `OFF_IRQ_STATUS))
                rdata_next = {1'b0, status_reg};
            else if (hit(req.addr, `OFF_IRQ_MASK))
                rdata_next = {1'b0, mask_reg};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            thr_reg            <= `RST_THRESHOLD;
            en_reg             <= 1'b0;
            result_reg         <= 1'b0;
            status_reg         <= 3'h0;
            mask_reg           <= 3'h0;
            state_reg          <= DET_OFF;
            cnt_reg            <= '0;
            rdata_o            <= 4'h0;
            irq_o              <= 1'b0;
            detector_enable_o  <= 1'b0;
            threshold_select_o <= `RST_THRESHOLD;
        end else begin
            thr_reg            <= thr_next;
            en_reg             <= en_next;
            result_reg         <= result_next;
            status_reg         <= status_next;
            mask_reg           <= mask_next;
            state_reg          <= state_next;
            cnt_reg            <= cnt_next;
            rdata_o            <= rdata_next;
            irq_o              <= irq_next;
            // Mirrors of the registers so the analogue side sees them with the bus
            detector_enable_o  <= en_next;
            threshold_select_o <= thr_next;
        end
    end
endmodule : supply_voltage_detect_ctrl

/* File: sim/svd_checker.sv */
// Port assertions for the supply voltage detector control block
`timescale 1ns/1ps
`include "svd_ctrl_defs.svh"
module svd_checker #(
    parameter int SETTLE_CYCLES = 8
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [3:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [3:0]  rdata_o,
    input  wire logic        cmp_below_i,
    input  wire logic        detector_enable_o,
    input  wire logic [3:0]  threshold_select_o,
    input  wire logic        irq_o
);
    // ========================================
    // Register and capture checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire wt = wr_i && addr_i == `OFF_THRESHOLD_SELECT;
    wire wc = wr_i && addr_i == `OFF_DETECTOR_CONTROL;
    wire rc = rd_i && addr_i == `OFF_DETECTOR_CONTROL;
    thr_write_a: assert property (wt |=> threshold_select_o == $past(wdata_i))
        else $error("threshold write lost");
    en_write_a: assert property (wc |=> detector_enable_o == $past(wdata_i[0]))
        else $error("enable write lost");
    thr_read_a: assert property (rd_i && addr_i == `OFF_THRESHOLD_SELECT |=>
        rdata_o == threshold_select_o) else $error("threshold read wrong");
    ctl_read_a: assert property (rc |=> rdata_o[3:2] == 2'h0 &&
        rdata_o[0] == detector_enable_o) else $error("control read wrong");
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 4'h0)
        else $error("read data outside read");
    out_hold_a: assert property (!wt && !wc |=>
        $stable({detector_enable_o, threshold_select_o})) else $error("output moved");
    rst_clear_a: assert property ($fell(sys_rst_i) |-> threshold_select_o == 4'h0 &&
        !detector_enable_o && !irq_o) else $error("reset values wrong");
    // The synchroniser lags two edges, so the pin must have been steady across that lag
    result_cap_a: assert property (wc && !wdata_i[0] && detector_enable_o &&
        $past(cmp_below_i, 4) == cmp_below_i && $past(cmp_below_i, 2) == cmp_below_i &&
        $past(cmp_below_i, 1) == cmp_below_i && $past(cmp_below_i, 3) == cmp_below_i
        ##2 rc |=> rdata_o[1] == $past(cmp_below_i, 3))
        else $error("captured result wrong");
endmodule : svd_checker
bind supply_voltage_detect_ctrl svd_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_svd_checker (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_below_i(cmp_below_i),
    .detector_enable_o(detector_enable_o), .threshold_select_o(threshold_select_o),
    .irq_o(irq_o));

/* File: sim/supply_voltage_detect_ctrl_test.sv */
// Register-level test of the supply voltage detector control block
`timescale 1ns/1ps
`include "svd_ctrl_defs.svh"
module supply_voltage_detect_ctrl_test;
    logic        sys_clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, cmp_below_i = 0;
    logic [15:0] addr_i = 16'h0000;
    logic [3:0]  wdata_i = 4'h0, rdata_o, threshold_select_o;
    logic        detector_enable_o, irq_o;
    int          errors = 0, checked = 0, cycles = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    // Short settle count keeps the run brief
    supply_voltage_detect_ctrl #(.SETTLE_CYCLES(8)) i_supply_voltage_detect_ctrl (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_below_i(cmp_below_i),
        .detector_enable_o(detector_enable_o), .threshold_select_o(threshold_select_o),
        .irq_o(irq_o));
    // ========================================
    // Check, bus and finish tasks
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [3:0] exp, input string what);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask : rd
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(`OFF_THRESHOLD_SELECT, 4'h0, "threshold");
        rd(`OFF_DETECTOR_CONTROL, 4'h0, "control");
        for (int i = 0; i < 16; i++) begin
            wr(`OFF_THRESHOLD_SELECT, 4'(i));
            chk("threshold pins", 4'(i), threshold_select_o);
            rd(`OFF_THRESHOLD_SELECT, 4'(i), "threshold");
        end
        wr(`OFF_IRQ_MASK, 4'h7);
        cmp_below_i <= 1'b1;
        wr(`OFF_DETECTOR_CONTROL, 4'h1);
        chk("enable pin", 4'h1, {3'h0, detector_enable_o});
        rd(`OFF_DETECTOR_CONTROL, 4'h1, "control");
        repeat (12) @(posedge sys_clk_i);
        wr(`OFF_DETECTOR_CONTROL, 4'h0);
        chk("enable pin off", 4'h0, {3'h0, detector_enable_o});
        rd(`OFF_DETECTOR_CONTROL, 4'h2, "low result");
        chk("irq", 4'h1, {3'h0, irq_o});
        rd(`OFF_IRQ_STATUS, 4'h3, "status");
        wr(`OFF_DETECTOR_CONTROL, 4'hE);
        cmp_below_i <= 1'b0;
        rd(`OFF_DETECTOR_CONTROL, 4'h2, "held result");
        wr(`OFF_IRQ_STATUS, 4'h7);
        chk("irq", 4'h0, {3'h0, irq_o});
        wr(`OFF_DETECTOR_CONTROL, 4'h1);
        wr(`OFF_DETECTOR_CONTROL, 4'h0);
        rd(`OFF_DETECTOR_CONTROL, 4'h0, "normal result");
        rd(`OFF_IRQ_STATUS, 4'h5, "early status");
        wr(`OFF_IRQ_MASK, 4'h0);
        chk("masked irq", 4'h0, {3'h0, irq_o});
        rd(16'hFF07, 4'h0, "unmapped");
        wr(`OFF_THRESHOLD_SELECT, 4'hF);
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(`OFF_THRESHOLD_SELECT, 4'h0, "threshold after reset");
        stop_test();
    end
endmodule : supply_voltage_detect_ctrl_test
